/* src/ccactl_top.sv */
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module ccactl_top
  import ccactl_pkg::*;
#(
  parameter int TICK_CNT = TICK_CYCLES
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RX_ON,
  input wire logic ED_SAMPLE_VALID,
  input wire logic [7:0] ED_SAMPLE,
  input wire logic SYNC_DETECT,
  input wire logic RX_FIFO_READ,
  output ccactl_pkg::ccactl_radio_s RADIO_REQ,
  output logic [1:0] IRQ_GROUP_ID,
  output logic [4:0] IRQ_SOURCE_ID,
  output logic IRQ
);
  import ccactl_pkg::*;

  logic [7:0] busy_threshold_q;
  logic [7:0] assessment_timeout_q;
  logic continuous_stop_q, idle_detect_mode_enable_q, continuous_mode_enable_q;
  logic single_assess_start_q, fast_carrier_check_enable_q, timeout_enable_q;
  logic [1:0] assess_result_q;
  logic [7:0] energy_value_q;
  logic [7:0] energy_ignore_level_q;
  logic [9:0] idle_wait_q;
  logic energy_capture_select_q;
  logic [2:0] energy_average_count_q;
  logic [1:0] irq_status_q, irq_mask_q;
  ccactl_state_e state_q;
  logic [15:0] tick_cnt_q;
  logic tick;
  logic [10:0] sample_cnt_q;
  logic [15:0] sum_q;
  logic [15:0] run_ticks_q;
  logic [10:0] idle_ticks_q;
  logic busy_seen_q;
  ccactl_radio_s radio_q;
  logic done_pulse, timeout_pulse;
  logic [7:0] avg_value;
  logic [7:0] avg_target;

  // Synchronisers for radio-side strobes and data
  logic [1:0] rx_on_s, ed_valid_s, sync_s, fifo_rd_s;
  logic [7:0] ed_s1, ed_s2;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_on_s <= 2'h0;
      ed_valid_s <= 2'h0;
      sync_s <= 2'h0;
      fifo_rd_s <= 2'h0;
      ed_s1 <= 8'h00;
      ed_s2 <= 8'h00;
    end else begin
      rx_on_s <= {rx_on_s[0], RX_ON};
      ed_valid_s <= {ed_valid_s[0], ED_SAMPLE_VALID};
      sync_s <= {sync_s[0], SYNC_DETECT};
      fifo_rd_s <= {fifo_rd_s[0], RX_FIFO_READ};
      ed_s1 <= ED_SAMPLE;
      ed_s2 <= ed_s1;
    end
  end
  logic rx_on, ed_valid, sync_hit, fifo_rd;
  logic ed_valid_d1, sync_d1, fifo_d1;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ed_valid_d1 <= 1'b0;
      sync_d1 <= 1'b0;
      fifo_d1 <= 1'b0;
    end else begin
      ed_valid_d1 <= ed_valid_s[1];
      sync_d1 <= sync_s[1];
      fifo_d1 <= fifo_rd_s[1];
    end
  end
  assign rx_on = rx_on_s[1];
  assign ed_valid = ed_valid_s[1] & ~ed_valid_d1;
  assign sync_hit = sync_s[1] & ~sync_d1;
  assign fifo_rd = fifo_rd_s[1] & ~fifo_d1;

  // APB decode
  logic wr_en, rd_en;
  assign wr_en = PSEL & PENABLE & PWRITE;
  assign rd_en = PSEL & PENABLE & ~PWRITE;
  assign PREADY = 1'b1;
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction
  logic mapped;
  assign mapped = hit(PADDR, ADDR_BUSY_THRESHOLD) | hit(PADDR, ADDR_ASSESS_TIMEOUT)
    | hit(PADDR, ADDR_CTRL_RESULT) | hit(PADDR, ADDR_ENERGY_VALUE)
    | (PADDR == ADDR_IGNORE_LEVEL) | (PADDR == ADDR_IDLE_WAIT) | (PADDR == ADDR_ENERGY_CFG)
    | (PADDR == ADDR_IRQ_STATUS) | (PADDR == ADDR_IRQ_MASK);
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  logic ctrl_wr;
  assign ctrl_wr = wr_en & hit(PADDR, ADDR_CTRL_RESULT);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      busy_threshold_q <= RST_BUSY_THRESHOLD;
      assessment_timeout_q <= RST_ASSESS_TIMEOUT;
      energy_ignore_level_q <= RST_IGNORE_LEVEL;
      idle_wait_q <= 10'h000;
      energy_capture_select_q <= 1'b0;
      energy_average_count_q <= RST_AVG_COUNT;
      irq_mask_q <= 2'h0;
    end else if (wr_en) begin
      if (hit(PADDR, ADDR_BUSY_THRESHOLD)) busy_threshold_q <= PWDATA[7:0];
      if (hit(PADDR, ADDR_ASSESS_TIMEOUT)) assessment_timeout_q <= PWDATA[7:0];
      if (PADDR == ADDR_IGNORE_LEVEL) energy_ignore_level_q <= PWDATA[7:0];
      if (PADDR == ADDR_IDLE_WAIT) idle_wait_q <= PWDATA[9:0];
      if (PADDR == ADDR_ENERGY_CFG) begin
        energy_capture_select_q <= PWDATA[3];
        energy_average_count_q <= PWDATA[2:0];
      end
      if (PADDR == ADDR_IRQ_MASK) irq_mask_q <= PWDATA[1:0];
    end
  end

  // Control bits; hardware self-clear of the start bit wins over a concurrent write
  logic stop_now;
  assign stop_now = continuous_stop_q;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      continuous_stop_q <= RST_CTRL[BIT_STOP];
      idle_detect_mode_enable_q <= RST_CTRL[BIT_IDLE_EN];
      continuous_mode_enable_q <= RST_CTRL[BIT_CONT_EN];
      single_assess_start_q <= RST_CTRL[BIT_SINGLE];
      fast_carrier_check_enable_q <= RST_CTRL[BIT_FAST];
      timeout_enable_q <= RST_CTRL[BIT_TMO_EN];
    end else begin
      if (ctrl_wr) begin
        continuous_stop_q <= PWDATA[BIT_STOP];
        idle_detect_mode_enable_q <= PWDATA[BIT_IDLE_EN];
        continuous_mode_enable_q <= PWDATA[BIT_CONT_EN];
        single_assess_start_q <= PWDATA[BIT_SINGLE];
        fast_carrier_check_enable_q <= PWDATA[BIT_FAST];
        timeout_enable_q <= PWDATA[BIT_TMO_EN];
      end else if (continuous_stop_q) begin
        continuous_mode_enable_q <= 1'b0;
        continuous_stop_q <= 1'b0;
      end
      if (done_pulse && !continuous_mode_enable_q) single_assess_start_q <= 1'b0;
    end
  end

  // 16 us tick
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) tick_cnt_q <= 16'h0000;
    else if (state_q == ST_IDLE || tick) tick_cnt_q <= 16'h0000;
    else tick_cnt_q <= tick_cnt_q + 16'h0001;
  end
  assign tick = (tick_cnt_q == 16'(TICK_CNT - 1));

  // Average target is 2^(n) samples, matching the default 8 samples of 128 us
  assign avg_target = 8'(1) << energy_average_count_q;
  assign avg_value = 8'(sum_q >> energy_average_count_q);

  logic want_run;
  assign want_run = single_assess_start_q | continuous_mode_enable_q | (fast_carrier_check_enable_q & rx_on);

  logic tmo_armed;
  assign tmo_armed = timeout_enable_q & idle_detect_mode_enable_q & (assessment_timeout_q != 8'h00);
  assign timeout_pulse = tmo_armed && state_q != ST_IDLE && tick
    && (run_ticks_q + 16'h0001 == 16'(assessment_timeout_q) * 16'(TIMEOUT_UNIT_TICKS));

  logic sample_ok;
  assign sample_ok = ed_valid && (ed_s2 <= energy_ignore_level_q);
  logic avg_full;
  assign avg_full = (sample_cnt_q[7:0] >= avg_target);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
      sample_cnt_q <= 11'h000;
      sum_q <= 16'h0000;
      run_ticks_q <= 16'h0000;
      idle_ticks_q <= 11'h000;
      busy_seen_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (want_run && !stop_now) begin
            state_q <= ST_AVERAGE;
            sample_cnt_q <= 11'h000;
            sum_q <= 16'h0000;
            run_ticks_q <= 16'h0000;
            idle_ticks_q <= 11'h000;
            busy_seen_q <= 1'b0;
          end
        end
        ST_AVERAGE: begin
          if (tick) run_ticks_q <= run_ticks_q + 16'h0001;
          if (timeout_pulse) state_q <= ST_IDLE;
          else if (sample_ok) begin
            sample_cnt_q <= sample_cnt_q + 11'h001;
            sum_q <= sum_q + 16'(ed_s2);
          end else if (avg_full) begin
            busy_seen_q <= (avg_value > busy_threshold_q);
            state_q <= (idle_detect_mode_enable_q && avg_value <= busy_threshold_q) ? ST_IDLE_WATCH : ST_DONE;
          end
        end
        ST_IDLE_WATCH: begin
          if (tick) begin
            run_ticks_q <= run_ticks_q + 16'h0001;
            idle_ticks_q <= idle_ticks_q + 11'h001;
          end
          if (timeout_pulse) state_q <= ST_IDLE;
          else if (ed_valid && ed_s2 > busy_threshold_q && ed_s2 <= energy_ignore_level_q) begin
            idle_ticks_q <= 11'h000; // Carrier restarts the idle window
          end else if (idle_ticks_q >= {1'b0, idle_wait_q}) state_q <= ST_DONE;
        end
        ST_DONE: state_q <= ST_IDLE;
      endcase
    end
  end
  assign done_pulse = (state_q == ST_DONE);

  // Result field: only hardware results or a software write of 00 change it
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) assess_result_q <= RES_FREE;
    else if (done_pulse) assess_result_q <= busy_seen_q ? RES_BUSY : RES_FREE;
    else if (state_q == ST_AVERAGE && ed_valid && !sample_ok) assess_result_q <= RES_IGNORE_EVAL;
    else if (state_q == ST_IDLE_WATCH) assess_result_q <= RES_IDLE_EVAL;
    else if (ctrl_wr && PWDATA[1:0] == RES_FREE) assess_result_q <= RES_FREE;
  end

  // Radio requests, one-cycle pulses
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) radio_q <= '0;
    else begin
      radio_q.transceiver_off_state_req <= timeout_pulse;
      radio_q.discard_req <= timeout_pulse;
      radio_q.sleep_req <= done_pulse && fast_carrier_check_enable_q && !busy_seen_q;
    end
  end
  assign RADIO_REQ = radio_q;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) energy_value_q <= 8'h00;
    else if (!energy_capture_select_q && rx_on && ed_valid) energy_value_q <= ed_s2;
    else if (energy_capture_select_q && (sync_hit || fifo_rd)) energy_value_q <= ed_s2;
  end

  // Bit0 completion, bit1 forced termination; set wins over write-one-to-clear
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) irq_status_q <= 2'h0;
    else irq_status_q <= (irq_status_q & ~((wr_en && PADDR == ADDR_IRQ_STATUS) ? PWDATA[1:0] : 2'h0))
      | {timeout_pulse, done_pulse};
  end
  assign IRQ = |(irq_status_q & irq_mask_q);
  assign IRQ_GROUP_ID = 2'(IRQ_GROUP_DONE);
  assign IRQ_SOURCE_ID = 5'(IRQ_SRC_DONE);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) PRDATA <= 32'h0000_0000;
    else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= 32'h0000_0000;
      if (hit(PADDR, ADDR_BUSY_THRESHOLD)) PRDATA[7:0] <= busy_threshold_q;
      if (hit(PADDR, ADDR_ASSESS_TIMEOUT)) PRDATA[7:0] <= assessment_timeout_q;
      if (hit(PADDR, ADDR_CTRL_RESULT)) PRDATA[7:0] <= {continuous_stop_q, idle_detect_mode_enable_q,
        continuous_mode_enable_q, single_assess_start_q, fast_carrier_check_enable_q, timeout_enable_q,
        assess_result_q};
      if (hit(PADDR, ADDR_ENERGY_VALUE)) PRDATA[7:0] <= energy_value_q;
      if (PADDR == ADDR_IGNORE_LEVEL) PRDATA[7:0] <= energy_ignore_level_q;
      if (PADDR == ADDR_IDLE_WAIT) PRDATA[9:0] <= idle_wait_q;
      if (PADDR == ADDR_ENERGY_CFG) PRDATA[3:0] <= {energy_capture_select_q, energy_average_count_q};
      if (PADDR == ADDR_IRQ_STATUS) PRDATA[1:0] <= irq_status_q;
      if (PADDR == ADDR_IRQ_MASK) PRDATA[1:0] <= irq_mask_q;
    end
  end
  logic unused_rd;
  assign unused_rd = rd_en;
endmodule

/* src/ccactl_pkg.sv */
package ccactl_pkg;
  localparam logic [7:0] ADDR_BUSY_THRESHOLD = 8'h37;
  localparam logic [7:0] ADDR_ASSESS_TIMEOUT = 8'h38;
  localparam logic [7:0] ADDR_CTRL_RESULT = 8'h39;
  localparam logic [7:0] ADDR_ENERGY_VALUE = 8'h3A;
  localparam int ADDR_IDX_W = 8;
  localparam logic [11:0] ADDR_IGNORE_LEVEL = 12'h0D8;
  localparam logic [11:0] ADDR_IDLE_WAIT = 12'h0EC;
  localparam logic [11:0] ADDR_ENERGY_CFG = 12'h104;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h1F0;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h1F4;
  localparam logic [7:0] RST_BUSY_THRESHOLD = 8'h5C;
  localparam logic [7:0] RST_ASSESS_TIMEOUT = 8'hFF;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_IGNORE_LEVEL = 8'hFE;
  localparam logic [2:0] RST_AVG_COUNT = 3'h3;
  localparam int BIT_STOP = 7;
  localparam int BIT_IDLE_EN = 6;
  localparam int BIT_CONT_EN = 5;
  localparam int BIT_SINGLE = 4;
  localparam int BIT_FAST = 3;
  localparam int BIT_TMO_EN = 2;
  localparam logic [1:0] RES_FREE = 2'h0;
  localparam logic [1:0] RES_BUSY = 2'h1;
  localparam logic [1:0] RES_IDLE_EVAL = 2'h2;
  localparam logic [1:0] RES_IGNORE_EVAL = 2'h3;
  localparam int IRQ_SRC_DONE = 18;
  localparam int IRQ_GROUP_DONE = 3;
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 16;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int TIMEOUT_UNIT_US = 128;
  localparam int TIMEOUT_UNIT_TICKS = TIMEOUT_UNIT_US / TICK_US;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_AVERAGE = 2'b01,
    ST_IDLE_WATCH = 2'b10,
    ST_DONE = 2'b11
  } ccactl_state_e;
  typedef struct packed {
    logic sleep_req;
    logic transceiver_off_state_req;
    logic discard_req;
  } ccactl_radio_s;
endpackage

/* verif/ccactl_monitor.sv */
`timescale 1ns/1ps
module ccactl_monitor
  import ccactl_pkg::*;
#(
  parameter int TICK_CNT = TICK_CYCLES
) (
  input logic CLK,
  input logic RSTN,
  input logic PSEL,
  input logic PENABLE,
  input logic PWRITE,
  input logic [11:0] PADDR,
  input logic [31:0] PWDATA,
  input logic [31:0] PRDATA,
  input logic PREADY,
  input logic PSLVERR,
  input ccactl_pkg::ccactl_radio_s RADIO_REQ,
  input logic [1:0] IRQ_GROUP_ID,
  input logic [4:0] IRQ_SOURCE_ID,
  input logic IRQ
);
  logic [7:0] thr_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Shadow copy, so a threshold register that never updates shows on readback
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      thr_q <= RST_BUSY_THRESHOLD;
    end else if (PSEL && PENABLE && PWRITE && PADDR == 12'h0DC) begin
      thr_q <= PWDATA[7:0];
    end
  end
  a_pready_high: assert property (PREADY) else $error("ready low");
  a_irq_ids: assert property (IRQ_GROUP_ID == 2'h3 && IRQ_SOURCE_ID == 5'h12)
    else $error("interrupt ids wrong");
  a_slverr_setup: assert property (!(PSEL && PENABLE) |-> !PSLVERR) else $error("error outside access");
  a_unmapped_err: assert property (PSEL && PENABLE && PADDR == 12'h0FC |-> PSLVERR) else $error("no error");
  a_unmapped_zero: assert property (PSEL && PENABLE && !PWRITE && PSLVERR |-> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_prdata_hold: assert property (!(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
    else $error("read data moved");
  a_thr_readback: assert property (PSEL && PENABLE && !PWRITE && PADDR == 12'h0DC |-> PRDATA == {24'h0, thr_q})
    else $error("threshold readback wrong");
  a_sleep_pulse: assert property (RADIO_REQ.sleep_req |=> !RADIO_REQ.sleep_req)
    else $error("sleep request too long");
  a_off_pulse: assert property (RADIO_REQ.transceiver_off_state_req |=> !RADIO_REQ.transceiver_off_state_req)
    else $error("off request too long");
endmodule

/* verif/tb_ccactl_top.sv */
`timescale 1ns/1ps
module tb_ccactl_top;
  import ccactl_pkg::*;
  localparam int TICKS = 4;
  logic CLK, PREADY, PSLVERR, IRQ, err;
  logic RSTN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, RX_ON = 1'b0;
  logic ED_SAMPLE_VALID = 1'b0, SYNC_DETECT = 1'b0, RX_FIFO_READ = 1'b0;
  logic [11:0] PADDR = 12'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic [7:0] ED_SAMPLE = 8'h0;
  logic [1:0] IRQ_GROUP_ID;
  logic [4:0] IRQ_SOURCE_ID;
  ccactl_radio_s RADIO_REQ;
  logic seen_sleep, seen_off, seen_drop;
  int miscompares = 0, checked = 0, cyc = 0, off_at = 0;
  ccactl_top #(.TICK_CNT(TICKS)) dut_u (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RX_ON(RX_ON), .ED_SAMPLE_VALID(ED_SAMPLE_VALID), .ED_SAMPLE(ED_SAMPLE), .SYNC_DETECT(SYNC_DETECT),
    .RX_FIFO_READ(RX_FIFO_READ), .RADIO_REQ(RADIO_REQ), .IRQ_GROUP_ID(IRQ_GROUP_ID),
    .IRQ_SOURCE_ID(IRQ_SOURCE_ID), .IRQ(IRQ));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // Radio requests are single pulses, so they are latched here for the scenarios
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (RSTN !== 1'b1) begin
      seen_sleep <= 1'b0;
      seen_off <= 1'b0;
      seen_drop <= 1'b0;
    end else begin
      if (RADIO_REQ.sleep_req === 1'b1) seen_sleep <= 1'b1;
      if (RADIO_REQ.discard_req === 1'b1) seen_drop <= 1'b1;
      if (RADIO_REQ.transceiver_off_state_req === 1'b1 && seen_off !== 1'b1) begin
        seen_off <= 1'b1;
        off_at <= cyc;
      end
    end
  end
  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; an extra edge after release keeps drivers from colliding
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge CLK);
      if (PREADY === 1'b1) break;
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
    if (n == 20) begin
      miscompares++;
      results();
    end
  endtask
  task automatic feed(input logic [7:0] v, input int cnt);
    repeat (cnt) begin
      ED_SAMPLE <= v;
      repeat (3) @(posedge CLK);
      ED_SAMPLE_VALID <= 1'b1;
      repeat (4) @(posedge CLK);
      ED_SAMPLE_VALID <= 1'b0;
      repeat (3) @(posedge CLK);
    end
  endtask
  task automatic dut_reset();
    RSTN <= 1'b0;
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
  endtask
  task automatic t_reset_values();
    apb(1'b0, 12'h0DC, 32'h0);
    chk("threshold", rd, 32'h5C);
    apb(1'b0, 12'h0E0, 32'h0);
    chk("timeout", rd, 32'hFF);
    apb(1'b0, 12'h0E4, 32'h0);
    chk("control", rd, 32'h0);
    apb(1'b0, 12'h0E8, 32'h0);
    chk("energy", rd, 32'h0);
    apb(1'b1, 12'h0FC, 32'h55);
    chk("write error", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("read error", {31'h0, err}, 32'h1);
  endtask
  task automatic t_carrier();
    int n;
    apb(1'b1, 12'h1F4, 32'h1);
    apb(1'b1, 12'h0DC, 32'h10);
    apb(1'b1, 12'h0E4, 32'h10);
    feed(8'h80, 10);
    for (n = 0; n < 200; n++) begin
      @(posedge CLK);
      if (IRQ === 1'b1) break;
    end
    chk("irq raised", {31'h0, IRQ}, 32'h1);
    if (n == 200) results();
    apb(1'b0, 12'h0E4, 32'h0);
    chk("control done", {24'h0, rd[7:0]}, 32'h01);
    apb(1'b0, 12'h0E8, 32'h0);
    chk("energy live", rd, 32'h80);
    // Writing 01 to the result field must leave it alone
    apb(1'b1, 12'h0E4, 32'h01);
    apb(1'b0, 12'h0E4, 32'h0);
    chk("result kept", {30'h0, rd[1:0]}, 32'h1);
    apb(1'b1, 12'h1F0, 32'h1);
    chk("irq cleared", {31'h0, IRQ}, 32'h0);
    apb(1'b1, 12'h0E4, 32'h0);
    apb(1'b0, 12'h0E4, 32'h0);
    chk("result cleared", {30'h0, rd[1:0]}, 32'h0);
  endtask
  task automatic t_fast();
    dut_reset();
    apb(1'b1, 12'h0DC, 32'hF0);
    apb(1'b1, 12'h0E4, 32'h08);
    feed(8'h20, 12);
    repeat (20) @(posedge CLK);
    chk("sleep", {31'h0, seen_sleep}, 32'h1);
    apb(1'b0, 12'h0E4, 32'h0);
    chk("free result", {30'h0, rd[1:0]}, 32'h0);
  endtask
  task automatic t_cont();
    dut_reset();
    apb(1'b1, 12'h0DC, 32'hF0);
    apb(1'b1, 12'h0E4, 32'h20);
    feed(8'h20, 16);
    apb(1'b0, 12'h0E4, 32'h0);
    chk("cont running", rd, 32'h20);
    apb(1'b0, 12'h1F0, 32'h0);
    chk("cont done", rd, 32'h1);
    apb(1'b1, 12'h0E4, 32'h80);
    apb(1'b0, 12'h0E4, 32'h0);
    chk("cont stopped", rd, 32'h0);
  endtask
  task automatic t_timeout(input logic [7:0] ctl, input logic [7:0] tmo, input logic exp);
    int start;
    int dt;
    dut_reset();
    apb(1'b1, 12'h0E0, {24'h0, tmo});
    apb(1'b1, 12'h0E4, {24'h0, ctl});
    start = cyc - 2;
    repeat (120) @(posedge CLK);
    dt = off_at - start;
    chk("off request", {31'h0, seen_off}, {31'h0, exp});
    chk("discard", {31'h0, seen_drop}, {31'h0, exp});
    // Expected delay is value x 8 ticks; slack covers input sync and tick phase
    if (exp) chk("off time", {31'h0, dt >= 26 && dt <= 40}, 32'h1);
  endtask
  initial begin
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    t_reset_values();
    RX_ON <= 1'b1;
    t_carrier();
    t_fast();
    t_cont();
    t_timeout(8'h54, 8'h01, 1'b1);
    t_timeout(8'h54, 8'h00, 1'b0);
    t_timeout(8'h14, 8'h01, 1'b0);
    results();
  end
endmodule
bind ccactl_top ccactl_monitor #(.TICK_CNT(TICK_CNT)) u_mon (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .RADIO_REQ(RADIO_REQ), .IRQ_GROUP_ID(IRQ_GROUP_ID), .IRQ_SOURCE_ID(IRQ_SOURCE_ID),
  .IRQ(IRQ));
